// File: hdl/irq_prio_regs.vh
// constants for the extended interrupt priority and vectoring block
// assumes an 8-bit register port and one 20 MHz system clock
// How it works
// - low reg A: eight sources, bit 7 down to 0
// - high reg A: same bits, high priority halves
// - low reg B: wake timer 2, timer3 1, uart1 0
// - high reg B: same three bits, upper five unused
// - level pairs low and high bit per source
// - code high,low: 00 lowest to 11 highest
// - flags polled and resolved every single clock
// - no call while equal or higher in service
// - call only on instruction's last cycle
// - no call on config write or return
// - blocked requests are never remembered
// - call pushes counter, not status word, then vectors
// - response clears flag only for chosen sources
// - return-from-interrupt ends current service routine
// - plain return leaves in-service markers set
// - core resumes from popped address unchecked
// - call takes four cycles, five minimum
// - worst single-interrupt latency is sixteen cycles
`ifndef IRQ_PRIO_REGS_VH
`define IRQ_PRIO_REGS_VH

// ****************************************************************
// register offsets and reset values
// ****************************************************************
`define OFS_PRIO_LOW_A   8'hef
`define OFS_PRIO_HIGH_A  8'hf7
`define OFS_PRIO_LOW_B   8'hfe
`define OFS_PRIO_HIGH_B  8'hff
`define OFS_SVC_STATUS   8'he0
`define OFS_LAST_SOURCE  8'he1
`define OFS_REQ_VIEW_A   8'he2
`define OFS_REQ_VIEW_B   8'he3
`define RST_PRIO         8'h00
`define PRIO_B_MASK      8'h07

// ****************************************************************
// field positions inside the priority registers
// ****************************************************************
`define BIT_TIMER_TWO    7
`define BIT_SERIAL_PERIPH 6
`define BIT_FAULT_BRAKE  5
`define BIT_WATCHDOG     4
`define BIT_PULSE_WIDTH  3
`define BIT_CAPTURE      2
`define BIT_PIN_IRQ      1
`define BIT_TWO_WIRE     0
`define BIT_WAKE_TIMER   2
`define BIT_TIMER_THREE  1
`define BIT_UART_ONE     0

// ****************************************************************
// source numbering, natural order (index 0 wins a tie)
// ****************************************************************
`define NUM_SRC          11
`define SRC_WATCHDOG     4'h0
`define SRC_TWO_WIRE     4'h1
`define SRC_PIN_IRQ      4'h2
`define SRC_FAULT_BRAKE  4'h3
`define SRC_SERIAL_PERIPH 4'h4
`define SRC_TIMER_TWO    4'h5
`define SRC_CAPTURE      4'h6
`define SRC_PULSE_WIDTH  4'h7
`define SRC_UART_ONE     4'h8
`define SRC_TIMER_THREE  4'h9
`define SRC_WAKE_TIMER   4'ha
// sources whose flag the response itself clears
`define AUTO_CLEAR_MASK  11'h200

// ****************************************************************
// timing
// ****************************************************************
`define CALL_CYCLES      3'h4
`define WORST_LATENCY    5'h10

`endif

// File: hdl/prio_level_decode.v
// one source's priority level from its low and high priority bits
// assumes the request is already gated by the source's enable
`timescale 1ns/10ps
module prio_level_decode
(
  input  wire       req,     // qualified request of this source
  input  wire       hiBit,   // high priority bit
  input  wire       loBit,   // low priority bit
  output wire       active,  // request present this cycle
  output wire [1:0] level    // 0 lowest .. 3 highest
);

  // high bit is the upper code bit, so 10 outranks 01
  assign level  = {hiBit, loBit};
  assign active = req;

endmodule // prio_level_decode

// File: hdl/inservice_tracker.v
// one marker per priority level for routines now in service
// assumes a set and a return never coincide; if so, clear then set
`timescale 1ns/10ps
module inservice_tracker
(
  input  wire       clk,        // system clock
  input  wire       sys_rst,    // synchronous reset, high
  input  wire       setEn,      // vector call granted
  input  wire [1:0] setLevel,   // level of the granted source
  input  wire       irqRetPulse,// return-from-interrupt executed
  output reg  [3:0] inService_q,// marker per level
  output reg  [1:0] topLevel,   // highest marked level
  output reg        anyActive   // some routine in service
);

  reg [3:0] inService_d;
  reg [3:0] topMask;

  // ****************************************************************
  // top marker search
  // ****************************************************************
  always @*
  begin
    topLevel = 2'h0;
    topMask  = 4'h0;
    if (inService_q[3])
    begin
      topLevel = 2'h3;
      topMask  = 4'h8;
    end
    else if (inService_q[2])
    begin
      topLevel = 2'h2;
      topMask  = 4'h4;
    end
    else if (inService_q[1])
    begin
      topLevel = 2'h1;
      topMask  = 4'h2;
    end
    else if (inService_q[0])
    begin
      topLevel = 2'h0;
      topMask  = 4'h1;
    end
    anyActive = |inService_q;
  end

  // a return clears only the highest marker, letting a preempted
  // lower routine keep its level blocked
  always @*
  begin
    inService_d = inService_q;
    if (irqRetPulse)
    begin
      inService_d = inService_d & ~topMask;
    end
    if (setEn)
    begin
      inService_d = inService_d | (4'h1 << setLevel);
    end
  end

  always @(posedge clk)
  begin
    if (sys_rst)
      inService_q <= 4'h0;
    else
      inService_q <= inService_d;
  end

endmodule // inservice_tracker

// File: hdl/irq_vector_ctrl.v
// priority resolution, vector call and return tracking
// assumes qualified request flags from the sources and a core that
// reports instruction boundaries, config writes and returns
`timescale 1ns/10ps
`include "irq_prio_regs.vh"
module irq_vector_ctrl
(
  input  wire        clk,              // system clock, 20 MHz
  input  wire        sys_rst,          // synchronous reset, high
  input  wire [7:0]  regAddr,          // register address
  input  wire [7:0]  regWdata,         // register write data
  input  wire        regWr,            // write strobe
  input  wire        regRd,            // read strobe
  output reg  [7:0]  regRdata_q,       // read data, cycle after strobe
  input  wire [10:0] irqReq,           // enabled request flags
  input  wire        instrLastCycle,   // last cycle of instruction
  input  wire        instrWritesCfg,   // instruction writes enable/prio
  input  wire        instrIsIrqRet,    // return-from-interrupt cycle
  output reg         vectorCall_q,     // one-cycle: push counter now
  output reg  [3:0]  vectorSrc_q,      // source being vectored
  output reg  [1:0]  vectorLevel_q,    // its priority level
  output reg         callBusy_q,       // call sequence under way
  output reg         serviceStart_q,   // one-cycle: routine starts
  output reg  [10:0] flagClear_q,      // one-cycle flag clear pulses
  output wire [3:0]  inService_q       // in-service marker per level
);

  // ****************************************************************
  // priority registers
  // ****************************************************************
  reg  [7:0] prioLowA_q;
  reg  [7:0] prioHighA_q;
  reg  [7:0] prioLowB_q;
  reg  [7:0] prioHighB_q;
  reg  [3:0] lastSrc_q;
  reg  [2:0] callCnt_q;

  wire       cfgWrite;
  wire       addrHit;

  assign addrHit = (regAddr == `OFS_PRIO_LOW_A) |
                   (regAddr == `OFS_PRIO_HIGH_A) |
                   (regAddr == `OFS_PRIO_LOW_B) |
                   (regAddr == `OFS_PRIO_HIGH_B);
  // a bus write to a priority register counts as a config write
  assign cfgWrite = instrWritesCfg | (regWr & addrHit);

  // software writes; unused upper bits of the B pair stay zero
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      prioLowA_q  <= `RST_PRIO;
      prioHighA_q <= `RST_PRIO;
      prioLowB_q  <= `RST_PRIO;
      prioHighB_q <= `RST_PRIO;
    end
    else if (regWr)
    begin
      if (regAddr == `OFS_PRIO_LOW_A)
        prioLowA_q <= regWdata;
      if (regAddr == `OFS_PRIO_HIGH_A)
        prioHighA_q <= regWdata;
      if (regAddr == `OFS_PRIO_LOW_B)
        prioLowB_q <= regWdata & `PRIO_B_MASK;
      if (regAddr == `OFS_PRIO_HIGH_B)
        prioHighB_q <= regWdata & `PRIO_B_MASK;
    end
  end

  // ****************************************************************
  // per-source bit gathering in natural order
  // ****************************************************************
  wire [10:0] srcLo;
  wire [10:0] srcHi;

  assign srcLo[`SRC_WATCHDOG]      = prioLowA_q[`BIT_WATCHDOG];
  assign srcLo[`SRC_TWO_WIRE]      = prioLowA_q[`BIT_TWO_WIRE];
  assign srcLo[`SRC_PIN_IRQ]       = prioLowA_q[`BIT_PIN_IRQ];
  assign srcLo[`SRC_FAULT_BRAKE]   = prioLowA_q[`BIT_FAULT_BRAKE];
  assign srcLo[`SRC_SERIAL_PERIPH] = prioLowA_q[`BIT_SERIAL_PERIPH];
  assign srcLo[`SRC_TIMER_TWO]     = prioLowA_q[`BIT_TIMER_TWO];
  assign srcLo[`SRC_CAPTURE]       = prioLowA_q[`BIT_CAPTURE];
  assign srcLo[`SRC_PULSE_WIDTH]   = prioLowA_q[`BIT_PULSE_WIDTH];
  assign srcLo[`SRC_UART_ONE]      = prioLowB_q[`BIT_UART_ONE];
  assign srcLo[`SRC_TIMER_THREE]   = prioLowB_q[`BIT_TIMER_THREE];
  assign srcLo[`SRC_WAKE_TIMER]    = prioLowB_q[`BIT_WAKE_TIMER];

  assign srcHi[`SRC_WATCHDOG]      = prioHighA_q[`BIT_WATCHDOG];
  assign srcHi[`SRC_TWO_WIRE]      = prioHighA_q[`BIT_TWO_WIRE];
  assign srcHi[`SRC_PIN_IRQ]       = prioHighA_q[`BIT_PIN_IRQ];
  assign srcHi[`SRC_FAULT_BRAKE]   = prioHighA_q[`BIT_FAULT_BRAKE];
  assign srcHi[`SRC_SERIAL_PERIPH] = prioHighA_q[`BIT_SERIAL_PERIPH];
  assign srcHi[`SRC_TIMER_TWO]     = prioHighA_q[`BIT_TIMER_TWO];
  assign srcHi[`SRC_CAPTURE]       = prioHighA_q[`BIT_CAPTURE];
  assign srcHi[`SRC_PULSE_WIDTH]   = prioHighA_q[`BIT_PULSE_WIDTH];
  assign srcHi[`SRC_UART_ONE]      = prioHighB_q[`BIT_UART_ONE];
  assign srcHi[`SRC_TIMER_THREE]   = prioHighB_q[`BIT_TIMER_THREE];
  assign srcHi[`SRC_WAKE_TIMER]    = prioHighB_q[`BIT_WAKE_TIMER];

  // ****************************************************************
  // level decode, one instance per source
  // ****************************************************************
  wire [10:0] srcActive;
  wire [21:0] srcLevel;

  genvar gi;
  generate
    for (gi = 0; gi < `NUM_SRC; gi = gi + 1)
    begin : g_src
      prio_level_decode u_dec
      (
        .req    (irqReq[gi]),
        .hiBit  (srcHi[gi]),
        .loBit  (srcLo[gi]),
        .active (srcActive[gi]),
        .level  (srcLevel[2*gi+1:2*gi])
      );
    end
  endgenerate

  // ****************************************************************
  // poll and resolve in the same cycle the flags are seen
  // ****************************************************************
  reg        winValid;
  reg [3:0]  winSrc;
  reg [1:0]  winLevel;
  integer    si;

  // descending scan with >= leaves the lowest index on a tie,
  // so equal levels fall back to natural order
  always @*
  begin
    winValid = 1'b0;
    winSrc   = 4'h0;
    winLevel = 2'h0;
    for (si = `NUM_SRC - 1; si >= 0; si = si - 1)
    begin
      if (srcActive[si] &&
          (!winValid || srcLevel[2*si+:2] >= winLevel))
      begin
        winValid = 1'b1;
        winSrc   = si[3:0];
        winLevel = srcLevel[2*si+:2];
      end
    end
  end

  // ****************************************************************
  // in-service markers
  // ****************************************************************
  wire [1:0] topLevel;
  wire       anyActive;
  wire       grant;
  wire       levelFree;

  // a new level must beat every level already in service
  assign levelFree = !anyActive || (winLevel > topLevel);

  // nothing here holds a request: a refused poll is simply lost
  // and the next cycle judges the flags afresh
  assign grant = winValid && levelFree &&
                 instrLastCycle &&
                 !cfgWrite && !instrIsIrqRet &&
                 !callBusy_q;

  // a plain subroutine return has no input here at all, so it
  // cannot touch the markers
  inservice_tracker u_track
  (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .setEn       (grant),
    .setLevel    (winLevel),
    .irqRetPulse (instrIsIrqRet),
    .inService_q (inService_q),
    .topLevel    (topLevel),
    .anyActive   (anyActive)
  );

  // ****************************************************************
  // hardware call sequence
  // ****************************************************************
  // the grant cycle is the detect cycle; the call then occupies
  // four cycles and the routine starts on the fifth
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      callCnt_q      <= 3'h0;
      callBusy_q     <= 1'b0;
      vectorCall_q   <= 1'b0;
      serviceStart_q <= 1'b0;
      vectorSrc_q    <= 4'h0;
      vectorLevel_q  <= 2'h0;
      lastSrc_q      <= 4'h0;
    end
    else
    begin
      vectorCall_q   <= grant;
      serviceStart_q <= (callCnt_q == 3'h1);
      if (grant)
      begin
        callCnt_q     <= `CALL_CYCLES;
        callBusy_q    <= 1'b1;
        vectorSrc_q   <= winSrc;
        vectorLevel_q <= winLevel;
        lastSrc_q     <= winSrc;
      end
      else if (callCnt_q != 3'h0)
      begin
        callCnt_q  <= callCnt_q - 3'h1;
        callBusy_q <= (callCnt_q > 3'h1);
      end
    end
  end

  // ****************************************************************
  // flag clear on response, only for sources that want it
  // ****************************************************************
  reg [10:0] winOneHot;

  always @*
  begin
    winOneHot = 11'h000;
    if (grant)
      winOneHot[winSrc] = 1'b1;
  end

  // sources outside the mask must be cleared by their own routine
  always @(posedge clk)
  begin
    if (sys_rst)
      flagClear_q <= 11'h000;
    else
      flagClear_q <= winOneHot & `AUTO_CLEAR_MASK;
  end

  // ****************************************************************
  // read side
  // ****************************************************************
  reg [7:0] rdMux;

  // unmapped addresses read as zero; the return address itself is
  // kept by the core and never checked here
  always @*
  begin
    case (regAddr)
      `OFS_PRIO_LOW_A:  rdMux = prioLowA_q;
      `OFS_PRIO_HIGH_A: rdMux = prioHighA_q;
      `OFS_PRIO_LOW_B:  rdMux = prioLowB_q;
      `OFS_PRIO_HIGH_B: rdMux = prioHighB_q;
      `OFS_SVC_STATUS:  rdMux = {3'h0, callBusy_q, inService_q};
      `OFS_LAST_SOURCE: rdMux = {4'h0, lastSrc_q};
      `OFS_REQ_VIEW_A:  rdMux = irqReq[7:0];
      `OFS_REQ_VIEW_B:  rdMux = {5'h00, irqReq[10:8]};
      default:          rdMux = 8'h00;
    endcase
  end

  // data stand only in the cycle after the strobe, zero otherwise
  always @(posedge clk)
  begin
    if (sys_rst)
      regRdata_q <= 8'h00;
    else if (regRd)
      regRdata_q <= rdMux;
    else
      regRdata_q <= 8'h00;
  end

endmodule // irq_vector_ctrl

// File: tb/irq_vector_ctrl_assertions.sv
// port checker for the interrupt vector controller
// assumes it is bound to irq_vector_ctrl, one clock, sync reset
`timescale 1ns/10ps
module irq_vector_ctrl_checker
(
  input wire        clk,            // system clock
  input wire        sys_rst,        // sync reset, high
  input wire [7:0]  regAddr,        // register address
  input wire [7:0]  regWdata,       // write data
  input wire        regWr,          // write strobe
  input wire        regRd,          // read strobe
  input wire [7:0]  regRdata_q,     // read data
  input wire [10:0] irqReq,         // request flags
  input wire        instrLastCycle, // instruction boundary
  input wire        instrWritesCfg, // config write
  input wire        instrIsIrqRet,  // return executed
  input wire        vectorCall_q,   // call pulse
  input wire [3:0]  vectorSrc_q,    // called source
  input wire [1:0]  vectorLevel_q,  // its level
  input wire        callBusy_q,     // call under way
  input wire        serviceStart_q, // routine starts
  input wire [10:0] flagClear_q,    // flag clears
  input wire [3:0]  inService_q     // level markers
);
  reg [10:0] reqPast_q;

  // last cycle's flags, indexed by the called source below
  always @(posedge clk)
    reqPast_q <= irqReq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ****************************************************************
  // call grant and sequence
  // ****************************************************************
  a_call_length: assert property (
    vectorCall_q |-> callBusy_q [*4] ##1 (!callBusy_q && serviceStart_q))
    else $error("call sequence length wrong");
  a_call_pulse: assert property (vectorCall_q |=> !vectorCall_q)
    else $error("call pulse longer than one cycle");
  a_no_equal_higher: assert property (
    vectorCall_q |-> ($past(inService_q) >> vectorLevel_q) == 4'h0)
    else $error("call while equal or higher level in service");
  a_only_last_cycle: assert property (vectorCall_q |-> $past(instrLastCycle))
    else $error("call off an instruction boundary");
  a_no_cfg_return: assert property (
    vectorCall_q |-> !$past(instrWritesCfg) && !$past(instrIsIrqRet))
    else $error("call during config write or return");
  a_live_request: assert property (vectorCall_q |-> reqPast_q[vectorSrc_q])
    else $error("call for a request no longer present");
  a_marker_set: assert property (vectorCall_q |-> inService_q[vectorLevel_q])
    else $error("marker of called level not set");
  a_return_clears: assert property (
    instrIsIrqRet && inService_q != 4'h0 |=>
      $countones(inService_q) == $countones($past(inService_q)) - 1)
    else $error("return did not clear one marker");
  a_flag_clear: assert property (
    flagClear_q != 11'h000 |->
      vectorCall_q && vectorSrc_q == 4'h9 && flagClear_q == 11'h200)
    else $error("flag clear outside timer three call");
  a_read_window: assert property (!$past(regRd) |-> regRdata_q == 8'h00)
    else $error("read data outside its cycle");

  // main scenarios
  c_top_level: cover property (vectorCall_q && vectorLevel_q == 2'h3);
  c_nested_return: cover property (instrIsIrqRet && inService_q[3] && inService_q[1]);
  c_auto_clear: cover property (flagClear_q != 11'h000);
endmodule // irq_vector_ctrl_checker

// File: tb/core_model.sv
// behavioural processor core facing the vector controller
// assumes the bench commands instruction boundaries and returns
`timescale 1ns/10ps
module core_model
(
  input  wire       clk,            // system clock
  input  wire       sys_rst,        // sync reset, high
  input  wire       lastEn,         // bench: boundary wanted
  input  wire       doIrqRet,       // bench: execute a return
  input  wire       vectorCall,     // call from controller
  input  wire       callBusy,       // call under way
  output wire       instrLastCycle, // instruction boundary
  output wire       instrIsIrqRet,  // return this cycle
  output reg  [3:0] depth_q         // return addresses stacked
);
  // the core runs no instruction of its own while the call occupies it
  assign instrLastCycle = lastEn && !callBusy;
  assign instrIsIrqRet = doIrqRet;

  // only the counter is stacked, no status word; a return pops unchecked
  always @(posedge clk)
    if (sys_rst)
      depth_q <= 4'h0;
    else if (vectorCall)
      depth_q <= depth_q + 4'h1;
    else if (doIrqRet && depth_q != 4'h0)
      depth_q <= depth_q - 4'h1;
endmodule // core_model

// File: tb/testbench.sv
// self-checking bench for the interrupt vector controller
// assumes a 20 MHz clock and the core model on the far side
`timescale 1ns/10ps
module testbench;
  typedef struct packed {
    logic [10:0] req;
    logic [7:0]  la, ha, lb, hb;
    logic [3:0]  src;
    logic [1:0]  lvl;
  } row_t;
  logic        clk, sys_rst, regWr, regRd, instrWritesCfg, lastEn, doIrqRet;
  logic [7:0]  regAddr, regWdata;
  logic [10:0] irqReq;
  wire  [7:0]  regRdata_q;
  wire         instrLastCycle, instrIsIrqRet, vectorCall_q, callBusy_q, serviceStart_q;
  wire  [3:0]  vectorSrc_q, inService_q, depth;
  wire  [1:0]  vectorLevel_q;
  wire  [10:0] flagClear_q;
  row_t        rows [6];
  int          n_mismatch = 0;
  int          compares = 0;

  core_model i_core (.clk(clk), .sys_rst(sys_rst), .lastEn(lastEn), .doIrqRet(doIrqRet),
    .vectorCall(vectorCall_q), .callBusy(callBusy_q), .instrLastCycle(instrLastCycle),
    .instrIsIrqRet(instrIsIrqRet), .depth_q(depth));
  irq_vector_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata_q(regRdata_q),
    .irqReq(irqReq), .instrLastCycle(instrLastCycle), .instrWritesCfg(instrWritesCfg),
    .instrIsIrqRet(instrIsIrqRet), .vectorCall_q(vectorCall_q), .vectorSrc_q(vectorSrc_q),
    .vectorLevel_q(vectorLevel_q), .callBusy_q(callBusy_q),
    .serviceStart_q(serviceStart_q), .flagClear_q(flagClear_q), .inService_q(inService_q));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // an edge always passes between two strobes of the same kind
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata_q;
  endtask

  // one polled cycle, then whether a call came out of it
  task automatic poll(input logic [10:0] r, input logic le, cf, rt, exp);
    @(posedge clk);
    irqReq <= r;
    lastEn <= le;
    instrWritesCfg <= cf;
    doIrqRet <= rt;
    @(posedge clk);
    irqReq <= 11'h000;
    lastEn <= 1'b0;
    instrWritesCfg <= 1'b0;
    doIrqRet <= 1'b0;
    #1 chk(vectorCall_q, exp);
  endtask

  task automatic svc;
    repeat (4) @(posedge clk);
    #1 chk(serviceStart_q, 16'h1);
  endtask

  task automatic retIrq;
    @(posedge clk);
    doIrqRet <= 1'b1;
    @(posedge clk);
    doIrqRet <= 1'b0;
    #1;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // cut a hang short well beyond the expected run of under two hundred cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    final_report;
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    logic [7:0] d;
    sys_rst = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
    irqReq = 11'h000;
    lastEn = 1'b0;
    instrWritesCfg = 1'b0;
    doIrqRet = 1'b0;
    rows[0] = '{11'h001, 8'h00, 8'h00, 8'h00, 8'h00, 4'h0, 2'h0};
    rows[1] = '{11'h7ff, 8'h00, 8'h00, 8'h00, 8'h00, 4'h0, 2'h0};
    rows[2] = '{11'h201, 8'h00, 8'h00, 8'h02, 8'h00, 4'h9, 2'h1};
    rows[3] = '{11'h011, 8'h00, 8'h40, 8'h00, 8'h00, 4'h4, 2'h2};
    rows[4] = '{11'h401, 8'h00, 8'h00, 8'h04, 8'h04, 4'ha, 2'h3};
    rows[5] = '{11'h0a2, 8'h80, 8'h08, 8'h00, 8'h00, 4'h7, 2'h2};
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    // ordinary cases: winner, level and auto clear per row
    for (int i = 0; i < 6; i++)
    begin
      wr(8'hef, rows[i].la);
      wr(8'hf7, rows[i].ha);
      wr(8'hfe, rows[i].lb);
      wr(8'hff, rows[i].hb);
      poll(rows[i].req, 1'b1, 1'b0, 1'b0, 1'b1);
      chk(vectorSrc_q, rows[i].src);
      chk(vectorLevel_q, rows[i].lvl);
      chk(flagClear_q, rows[i].src == 4'h9 ? 16'h200 : 16'h0);
      svc;
      retIrq;
      chk(inService_q, 16'h0);
    end
    // nesting: watchdog at level 1, pin interrupt at level 3
    wr(8'hef, 8'h12);
    wr(8'hf7, 8'h02);
    wr(8'hfe, 8'h00);
    wr(8'hff, 8'h00);
    poll(11'h001, 1'b1, 1'b0, 1'b0, 1'b1);
    svc;
    chk(inService_q, 16'h2);
    poll(11'h002, 1'b1, 1'b0, 1'b0, 1'b0);
    poll(11'h001, 1'b1, 1'b0, 1'b0, 1'b0);
    poll(11'h004, 1'b1, 1'b0, 1'b0, 1'b1);
    chk(vectorLevel_q, 16'h3);
    svc;
    chk(inService_q, 16'ha);
    // status and last source views while two routines are nested
    rd(8'he0, d);
    chk(d, 16'h0a);
    rd(8'he1, d);
    chk(d, 16'h2);
    chk(depth, 16'h2);
    retIrq;
    chk(inService_q, 16'h2);
    retIrq;
    chk(inService_q, 16'h0);
    chk(depth, 16'h0);
    // blocked requests are neither served nor remembered
    poll(11'h001, 1'b0, 1'b0, 1'b0, 1'b0);
    poll(11'h000, 1'b1, 1'b0, 1'b0, 1'b0);
    poll(11'h001, 1'b1, 1'b1, 1'b0, 1'b0);
    poll(11'h001, 1'b1, 1'b0, 1'b1, 1'b0);
    // second reset in mid-run, then register map
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(8'hef, d);
    chk(d, 16'h0);
    rd(8'hf7, d);
    chk(d, 16'h0);
    rd(8'hfe, d);
    chk(d, 16'h0);
    rd(8'hff, d);
    chk(d, 16'h0);
    wr(8'hef, 8'ha5);
    rd(8'hef, d);
    chk(d, 16'ha5);
    wr(8'hf7, 8'h5a);
    rd(8'hf7, d);
    chk(d, 16'h5a);
    wr(8'hfe, 8'hff);
    rd(8'hfe, d);
    chk(d, 16'h07);
    wr(8'hff, 8'hff);
    rd(8'hff, d);
    chk(d, 16'h07);
    wr(8'ha0, 8'hff);
    rd(8'ha0, d);
    chk(d, 16'h0);
    // request views; no boundary is offered, so no call starts
    @(posedge clk);
    irqReq <= 11'h4a5;
    rd(8'he2, d);
    chk(d, 16'ha5);
    rd(8'he3, d);
    chk(d, 16'h4);
    final_report;
  end
endmodule // testbench

bind irq_vector_ctrl irq_vector_ctrl_checker i_chk (.clk(clk), .sys_rst(sys_rst),
  .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata_q(regRdata_q), .irqReq(irqReq), .instrLastCycle(instrLastCycle),
  .instrWritesCfg(instrWritesCfg), .instrIsIrqRet(instrIsIrqRet), .vectorCall_q(vectorCall_q),
  .vectorSrc_q(vectorSrc_q), .vectorLevel_q(vectorLevel_q), .callBusy_q(callBusy_q),
  .serviceStart_q(serviceStart_q), .flagClear_q(flagClear_q), .inService_q(inService_q));
